// File: rtl/tca_transfer_ctrl.sv
// transfer controller activation, descriptor engine and register slave
//
// Summary of operation
// - stop bit set keeps the idle controller from starting
// - writing stop bit 1 ignored while busy
// - stop register resets to 3fff
// - fetch descriptor, transfer, write descriptor back
// - chain bit continues to next descriptor
// - normal, repeat or block transfer mode
// - source and destination addresses are 24 bits
// - normal mode moves one unit, steps 1/2
// - repeat mode restores address and count
// - block mode moves whole block, either side
// - activation by peripherals or software vector write
// - enable bit routes source to controller or CPU
// - clear flag or enable after last transfer
// - software, select 0, not ended: clear enable
// - software, select 1 or ended: keep, interrupt
// - source, select 0, not ended: clear flag
// - source, select 1 or ended: clear enable
// - controller service ignores CPU mask and priorities
// - simultaneous requests served in fixed order
// - software vector is 400 plus vector twice
// - descriptor words in fixed order, chained contiguous
// - counter decrements per transfer, ends at zero
//
// Design decisions made here: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ps
module tca_transfer_ctrl
  import tca_pkg::*;
(
  // clock, reset, enable
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // peripheral request flags
  input wire logic [tca_pkg::NSRC-1:0] srcReq,
  output logic [tca_pkg::NSRC-1:0] srcFlagClr,
  // interrupts to the cpu side
  output logic [tca_pkg::NSRC-1:0] cpuSrcIrq,
  output logic swCpuIrq,
  // memory master
  output logic memReq,
  output logic memWe,
  output logic memWord,
  output logic [tca_pkg::AW-1:0] memAddr,
  output logic [tca_pkg::DW-1:0] memWdata,
  input wire logic memAck,
  input wire logic [tca_pkg::DW-1:0] memRdata,
  // status
  output logic busy,
  output logic stopped
);
  import tca_pkg::*;

  tca_regs_t q; // registered state
  tca_regs_t d; // next state
  logic hwAny; // some enabled source pending
  logic [IW-1:0] hwIdx; // winning source
  logic [AW-1:0] stepS; // source step size
  logic [AW-1:0] stepD; // destination step size
  logic [AW-1:0] nSrc; // stepped source address
  logic [AW-1:0] nDst; // stepped destination address
  logic [AW-1:0] rewind; // area length in bytes
  logic [7:0] cntLo; // decremented low count
  logic [15:0] cntFull; // decremented full count A
  logic [15:0] cntBlk; // decremented count B
  logic bSide; // repeat / block area on source side
  logic [1:0] mode;
  logic writeNow; // bus data phase of a write

  // only sources whose enable is 1 reach the picker; the rest stay
  // with the cpu, so the cpu mask plays no part here; a flag whose clear
  // is in flight still reads high for one cycle, so it is masked to keep
  // one request from being served twice
  tca_prio #(.N(NSRC), .W(IW)) u_prio (
    .req(srcReq & q.srcEn & ~q.flagClr),
    .any(hwAny),
    .idx(hwIdx)
  );

  // descriptor half word in memory order
  function automatic logic [DW-1:0] descWord(input tca_regs_t s,
                                             input logic [2:0] i);
    case (i)
      3'h0: descWord = {s.modeA, s.srcAddr[23:16]};
      3'h1: descWord = s.srcAddr[15:0];
      3'h2: descWord = {s.modeB, s.dstAddr[23:16]};
      3'h3: descWord = s.dstAddr[15:0];
      3'h4: descWord = s.cntA;
      default: descWord = s.cntB;
    endcase
  endfunction : descWord

  // step by 1 or 2 in the chosen direction, or stay
  function automatic logic [AW-1:0] stepAddr(input logic [AW-1:0] a,
                                             input logic [1:0] ctl,
                                             input logic [AW-1:0] st);
    if (!ctl[1]) begin
      stepAddr = a;
    end else if (ctl[0]) begin
      stepAddr = a - st;
    end else begin
      stepAddr = a + st;
    end
  endfunction : stepAddr

  // register read mux
  function automatic logic [31:0] regRead(input tca_regs_t s,
                                          input logic [7:0] a);
    case (a)
      OFS_MSTOP: regRead = {16'h0000, s.mstop};
      OFS_SRCEN: regRead = {24'h000000, s.srcEn};
      OFS_SWVEC: regRead = {24'h000000, s.swEn, s.swVec};
      OFS_STAT: regRead = {28'h0000000, s.swHold, s.mstop[STOP_BIT],
                           s.isSw, s.state != S_IDLE};
      default: regRead = 32'h00000000; // unmapped reads as zero
    endcase
  endfunction : regRead

  // datapath helpers for one transfer unit
  always_comb begin
    mode = q.modeA[MA_MD+1:MA_MD];
    bSide = q.modeA[MA_BSIDE];
    stepS = {22'h000000, q.modeA[MA_SZ], ~q.modeA[MA_SZ]};
    stepD = stepS;
    nSrc = stepAddr(q.srcAddr, q.modeA[MA_SM+1:MA_SM], stepS);
    nDst = stepAddr(q.dstAddr, q.modeA[MA_DM+1:MA_DM], stepD);
    // a high count of zero means 256 units
    rewind = {14'h0000, (q.cntA[15:8] == 8'h00), q.cntA[15:8], 1'b0}
             >> (q.modeA[MA_SZ] ? 0 : 1);
    cntLo = q.cntA[7:0] - 8'h01;
    cntFull = q.cntA - 16'h0001;
    cntBlk = q.cntB - 16'h0001;
    writeNow = q.hSel && q.hWrite;
  end

  // next state
  always_comb begin
    d = q;
    d.flagClr = '0;
    d.swIrq = 1'b0;
    d.memReq = 1'b0;
    d.memWe = 1'b0;
    case (q.state)
      // pick an activation; a stopped controller starts nothing
      S_IDLE: begin
        if (!q.mstop[STOP_BIT]) begin
          if (q.swEn && !q.swHold) begin
            d.isSw = 1'b1;
            d.memAddr = SW_VEC_BASE + {16'h0000, q.swVec, 1'b0};
            d.state = S_VEC;
            d.memReq = 1'b1;
          end else if (hwAny) begin
            d.isSw = 1'b0;
            d.srcIdx = hwIdx;
            d.memAddr = HW_VEC_BASE + {20'h00000, hwIdx, 1'b0};
            d.state = S_VEC;
            d.memReq = 1'b1;
          end
        end
        d.memWord = 1'b1;
      end
      // vector holds the low half of the descriptor address
      S_VEC: begin
        d.memReq = !memAck;
        if (memAck) begin
          d.ptr = {DESC_PAGE, memRdata};
          d.widx = 3'h0;
          d.memAddr = {DESC_PAGE, memRdata};
          d.memReq = 1'b1;
          d.state = S_FETCH;
        end
      end
      // read the six descriptor half words
      S_FETCH: begin
        d.memReq = 1'b1;
        if (memAck) begin
          case (q.widx)
            3'h0: {d.modeA, d.srcAddr[23:16]} = memRdata;
            3'h1: d.srcAddr[15:0] = memRdata;
            3'h2: {d.modeB, d.dstAddr[23:16]} = memRdata;
            3'h3: d.dstAddr[15:0] = memRdata;
            3'h4: d.cntA = memRdata;
            default: d.cntB = memRdata;
          endcase
          d.widx = q.widx + 3'h1;
          d.memAddr = q.memAddr + 24'h000002;
          if (q.widx == DESC_LAST) begin
            d.memAddr = q.srcAddr;
            d.memWord = q.modeA[MA_SZ];
            d.state = S_SRD;
          end
        end
      end
      // read one unit from the source
      S_SRD: begin
        d.memReq = 1'b1;
        if (memAck) begin
          d.data = memRdata;
          d.memAddr = q.dstAddr;
          d.memWdata = memRdata;
          d.memWe = 1'b1;
          d.state = S_DWR;
        end
      end
      // write the unit, then step addresses and counts
      S_DWR: begin
        d.memReq = 1'b1;
        d.memWe = 1'b1;
        if (memAck) begin
          d.srcAddr = nSrc;
          d.dstAddr = nDst;
          d.ended = 1'b0;
          d.state = S_WBACK;
          d.memWe = 1'b1;
          d.memWord = 1'b1;
          d.widx = 3'h0;
          case (mode)
            MD_REPEAT: begin
              d.cntA[7:0] = cntLo;
              if (cntLo == 8'h00) begin
                d.cntA[7:0] = q.cntA[15:8];
                if (bSide) begin
                  d.srcAddr = stepAddr(nSrc, {1'b1, ~q.modeA[MA_SM]},
                                       rewind);
                end else begin
                  d.dstAddr = stepAddr(nDst, {1'b1, ~q.modeA[MA_DM]},
                                       rewind);
                end
              end
            end
            MD_BLOCK: begin
              d.cntA[7:0] = cntLo;
              if (cntLo != 8'h00) begin
                d.memAddr = nSrc;
                d.memWord = q.modeA[MA_SZ];
                d.memWe = 1'b0;
                d.state = S_SRD;
              end else begin
                d.cntA[7:0] = q.cntA[15:8];
                d.cntB = cntBlk;
                d.ended = (cntBlk == 16'h0000);
                if (bSide) begin
                  d.srcAddr = stepAddr(nSrc, {1'b1, ~q.modeA[MA_SM]},
                                       rewind);
                end else begin
                  d.dstAddr = stepAddr(nDst, {1'b1, ~q.modeA[MA_DM]},
                                       rewind);
                end
              end
            end
            default: begin
              d.cntA = cntFull;
              d.ended = (cntFull == 16'h0000);
            end
          endcase
          if (d.state == S_WBACK) begin
            d.memAddr = q.ptr;
            d.memWdata = descWord(d, 3'h0);
          end
        end
      end
      // write the updated descriptor back, then chain or finish
      S_WBACK: begin
        d.memReq = 1'b1;
        d.memWe = 1'b1;
        if (memAck) begin
          d.widx = q.widx + 3'h1;
          d.memAddr = q.memAddr + 24'h000002;
          d.memWdata = descWord(q, q.widx + 3'h1);
          if (q.widx == DESC_LAST) begin
            d.memWe = 1'b0;
            if (q.modeB[MB_CHAIN]) begin
              d.ptr = q.ptr + DESC_BYTES;
              d.memAddr = q.ptr + DESC_BYTES;
              d.widx = 3'h0;
              d.state = S_FETCH;
            end else begin
              d.memReq = 1'b0;
              d.state = S_DONE;
            end
          end
        end
      end
      // last descriptor decides what is cleared
      S_DONE: begin
        d.state = S_IDLE;
        if (!q.modeB[MB_INTERRUPT_SELECT] && !q.ended) begin
          if (q.isSw) begin
            d.swEn = 1'b0;
          end else begin
            d.flagClr[q.srcIdx] = 1'b1;
          end
        end else if (q.isSw) begin
          d.swHold = 1'b1;
          d.swIrq = 1'b1;
        end else begin
          d.srcEn[q.srcIdx] = 1'b0;
        end
      end
      default: begin
        d.state = S_IDLE;
      end
    endcase

    // bus data phase write; a software set wins over a hardware clear
    if (writeNow) begin
      case (q.hAddr)
        OFS_MSTOP: begin
          d.mstop = hwdata[15:0];
          if (q.state != S_IDLE && !q.mstop[STOP_BIT]) begin
            d.mstop[STOP_BIT] = 1'b0;
          end
        end
        OFS_SRCEN: begin
          d.srcEn = hwdata[NSRC-1:0];
        end
        OFS_SWVEC: begin
          d.swVec = hwdata[6:0];
          d.swRdOne = 1'b0;
          if (hwdata[SWEN_BIT]) begin
            d.swEn = 1'b1;
            d.swHold = 1'b0;
          end else if (q.swRdOne) begin
            d.swEn = 1'b0;
            d.swHold = 1'b0;
          end
        end
        default: begin
          d.hSel = 1'b0; // unmapped writes are dropped
        end
      endcase
    end

    // bus address phase; zero wait states, always okay
    d.hSel = hsel && htrans[1] && hready;
    d.hWrite = hwrite;
    d.hAddr = {haddr[7:2], 2'b00};
    d.hready = 1'b1;
    if (hsel && htrans[1] && hready && !hwrite) begin
      d.hrdata = regRead(q, {haddr[7:2], 2'b00});
      if ({haddr[7:2], 2'b00} == OFS_SWVEC && q.swEn) begin
        d.swRdOne = 1'b1;
      end
    end

    // sources not given to the controller go to the cpu
    d.cpuReq = srcReq & ~d.srcEn;

    // status kept in flops, same timing as the state itself
    d.busy = (d.state != S_IDLE);
    d.stopped = d.mstop[STOP_BIT] && (d.state == S_IDLE);
  end

  // state register; clock enable low freezes everything but reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q <= TCA_RST;
    end else if (ce) begin
      q <= d;
    end
  end

  // outputs straight from the state register; hresp tied to okay
  assign hreadyout = q.hready;
  assign hresp = 1'b0;
  assign hrdata = q.hrdata;
  assign srcFlagClr = q.flagClr;
  assign cpuSrcIrq = q.cpuReq;
  assign swCpuIrq = q.swIrq;
  assign memReq = q.memReq;
  assign memWe = q.memWe;
  assign memWord = q.memWord;
  assign memAddr = q.memAddr;
  assign memWdata = q.memWdata;
  assign busy = q.busy;
  assign stopped = q.stopped;
endmodule : tca_transfer_ctrl

// File: include/tca_pkg.sv
// constants, register map and state types of the transfer controller
package tca_pkg;
  // sizes
  localparam int NSRC = 8; // peripheral activation sources
  localparam int AW = 24; // source and destination address width
  localparam int DW = 16; // memory data path width
  localparam int IW = 3; // source index width
  // register byte offsets on the bus
  localparam logic [7:0] OFS_MSTOP = 8'h00; // module_stop_control
  localparam logic [7:0] OFS_SRCEN = 8'h04; // source_enable_bits
  localparam logic [7:0] OFS_SWVEC = 8'h08; // software_vector_register
  localparam logic [7:0] OFS_STAT = 8'h0c; // status
  // reset values
  localparam logic [15:0] MSTOP_RST = 16'h3fff;
  localparam logic [NSRC-1:0] SRCEN_RST = 8'h00;
  localparam logic [6:0] SWVEC_RST = 7'h00;
  // field positions
  localparam int STOP_BIT = 14; // xfer_ctrl_stop_bit
  localparam int SWEN_BIT = 7; // software_activation_enable
  localparam int MA_SM = 6; // mode_word_a source step, 2 bits
  localparam int MA_DM = 4; // mode_word_a destination step, 2 bits
  localparam int MA_MD = 2; // mode_word_a transfer mode, 2 bits
  localparam int MA_BSIDE = 1; // repeat / block area on source side
  localparam int MA_SZ = 0; // 1 = word transfer
  localparam int MB_CHAIN = 7; // chain_enable
  localparam int MB_INTERRUPT_SELECT = 6; // interrupt_select
  // transfer modes
  localparam logic [1:0] MD_NORMAL = 2'h0;
  localparam logic [1:0] MD_REPEAT = 2'h1;
  localparam logic [1:0] MD_BLOCK = 2'h2;
  // vector and descriptor addresses
  localparam logic [AW-1:0] SW_VEC_BASE = 24'h000400;
  localparam logic [AW-1:0] HW_VEC_BASE = 24'h000420;
  localparam logic [7:0] DESC_PAGE = 8'hff; // upper byte of descriptors
  localparam logic [2:0] DESC_LAST = 3'h5; // six half words per descriptor
  localparam logic [AW-1:0] DESC_BYTES = 24'h00000c;

  // controller sequence
  typedef enum logic [2:0] {
    S_IDLE, S_VEC, S_FETCH, S_SRD, S_DWR, S_WBACK, S_DONE
  } tca_state_t;

  // whole state of the controller
  typedef struct packed {
    tca_state_t state;
    logic [15:0] mstop;
    logic [NSRC-1:0] srcEn;
    logic swEn;
    logic [6:0] swVec;
    logic swRdOne; // swEn was read as 1
    logic swHold; // software run finished with swEn kept
    logic isSw;
    logic [IW-1:0] srcIdx;
    logic [AW-1:0] ptr;
    logic [2:0] widx;
    logic [7:0] modeA;
    logic [AW-1:0] srcAddr;
    logic [7:0] modeB;
    logic [AW-1:0] dstAddr;
    logic [15:0] cntA;
    logic [15:0] cntB;
    logic [DW-1:0] data;
    logic ended;
    logic memReq;
    logic memWe;
    logic memWord;
    logic [AW-1:0] memAddr;
    logic [DW-1:0] memWdata;
    logic [NSRC-1:0] flagClr;
    logic [NSRC-1:0] cpuReq;
    logic swIrq;
    logic hSel;
    logic hWrite;
    logic [7:0] hAddr;
    logic [31:0] hrdata;
    logic hready;
    logic busy; // registered copy of state not idle
    logic stopped; // registered stop bit and idle
  } tca_regs_t;

  localparam tca_regs_t TCA_RST = '{
    state: S_IDLE, mstop: MSTOP_RST, srcEn: SRCEN_RST, swVec: SWVEC_RST,
    hready: 1'b1, default: '0
  };
endpackage : tca_pkg

// File: rtl/tca_prio.sv
// fixed-priority picker: lowest index wins
`timescale 1ns/1ps
module tca_prio #(
  parameter int N = 8,
  parameter int W = 3
) (
  // requests
  input wire logic [N-1:0] req,
  // result
  output logic any,
  output logic [W-1:0] idx
);
  // scan from the top so the lowest index is written last
  always_comb begin
    any = |req;
    idx = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (req[i]) begin
        idx = W'(i);
      end
    end
  end
endmodule : tca_prio

// File: testbench/tca_transfer_ctrl_props.sv
// concurrent checks on the transfer controller ports
`timescale 1ns/1ps
module tca_transfer_ctrl_props (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // bus and status
  input wire logic hresp,
  input wire logic busy,
  input wire logic stopped,
  // requests and interrupts
  input wire logic [tca_pkg::NSRC-1:0] srcReq,
  input wire logic [tca_pkg::NSRC-1:0] srcFlagClr,
  input wire logic [tca_pkg::NSRC-1:0] cpuSrcIrq,
  input wire logic swCpuIrq,
  // memory master
  input wire logic memReq,
  input wire logic memWe,
  input wire logic memWord,
  input wire logic [tca_pkg::AW-1:0] memAddr,
  input wire logic memAck
);
  import tca_pkg::*;
  // one domain, so one clock and one disable
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  hresp_ok_a: assert property (!hresp)
    else $error("bus response not okay");
  stop_idle_a: assert property (stopped |-> !busy && !memReq)
    else $error("stopped while moving data");
  // a request may not move or vanish before its answer
  mem_hold_a: assert property (memReq && !memAck |=>
    memReq && $stable(memAddr) && $stable(memWe))
    else $error("memory request dropped or changed");
  clr_one_a: assert property (|srcFlagClr |->
    $onehot(srcFlagClr) && !memReq)
    else $error("flag clear not single or too early");
  clr_pulse_a: assert property (|srcFlagClr |=> srcFlagClr == '0)
    else $error("flag clear longer than a cycle");
  sw_irq_a: assert property (swCpuIrq |-> !memReq ##1 !swCpuIrq)
    else $error("software interrupt mistimed");
  // only a source raised the cycle before reaches the cpu
  route_cpu_a: assert property (
    (cpuSrcIrq & ~$past(srcReq)) == '0)
    else $error("cpu interrupt without request");
  vec_rd_a: assert property ($rose(busy) |-> ##[0:3]
    memReq && !memWe && memAddr[23:10] == 14'h0001)
    else $error("first access not a vector read");
  // descriptor half words always move as whole words
  desc_word_a: assert property (
    memReq && memAddr[23:16] == DESC_PAGE |-> memWord)
    else $error("descriptor access not word wide");
  // main scenarios
  cover property (|srcFlagClr);
  cover property (swCpuIrq);
  cover property ($rose(stopped));
endmodule : tca_transfer_ctrl_props

// File: testbench/tca_mem_model.sv
// memory partner: sparse word store, answers fast and slow in turn
`timescale 1ns/1ps
module tca_mem_model (
  // clock
  input wire logic clk,
  // request side
  input wire logic memReq,
  input wire logic memWe,
  input wire logic memWord,
  input wire logic [tca_pkg::AW-1:0] memAddr,
  input wire logic [tca_pkg::DW-1:0] memWdata,
  // answer side
  output logic memAck,
  output logic [tca_pkg::DW-1:0] memRdata
);
  import tca_pkg::*;
  logic [15:0] m [int]; // word store, keyed by half address
  int dly = 0; // wait left on this request
  int cnt = 0; // access count, picks the latency
  initial begin
    memAck = 1'b0;
    memRdata = 16'h0000;
  end
  // ack one cycle after or later; no ack at the edge that took one
  always @(posedge clk) begin
    memAck <= 1'b0;
    memRdata <= ~memRdata; // stale data never looks valid
    if (memReq && !memAck) begin
      if (dly > 0) begin
        dly <= dly - 1;
      end else begin
        memAck <= 1'b1;
        dly <= cnt % 3;
        cnt <= cnt + 1;
        // descriptor words sit in order, word wide only
        if (memWe) m[int'(memAddr[23:1])] = memWdata;
        else memRdata <= m[int'(memAddr[23:1])];
      end
    end
  end
endmodule : tca_mem_model

// File: testbench/tb_top.sv
// self-checking bench for the transfer controller
`timescale 1ns/1ps
module tb_top;
  import tca_pkg::*;
  // one descriptor run: inputs, then expected write-back
  typedef struct {
    logic [7:0] ma, mb;
    logic [15:0] ca, cb, es, ed, eca, ecb;
    logic een;
  } tca_row_t;
  logic clk, rst_n, ce, hsel, hwrite, hreadyout, hresp, busy, stopped;
  logic memReq, memWe, memWord, memAck, swCpuIrq;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [NSRC-1:0] srcReq, srcFlagClr, cpuSrcIrq;
  logic [AW-1:0] memAddr, firstA;
  logic [DW-1:0] memWdata, memRdata;
  int num_errors, n_tests, nAcc, nClr, nIrq, a0, c0;
  tca_row_t r;
  tca_row_t rows [5] = '{
    '{8'ha1, 8'h00, 16'h2, 16'h0, 16'h1002, 16'h2002, 16'h1, 16'h0, 1'b1},
    '{8'ha1, 8'h00, 16'h1, 16'h0, 16'h1002, 16'h2002, 16'h0, 16'h0, 1'b0},
    '{8'ha1, 8'h40, 16'h2, 16'h0, 16'h1002, 16'h2002, 16'h1, 16'h0, 1'b0},
    '{8'h87, 8'h00, 16'h101, 16'h0, 16'h1000, 16'h2000, 16'h101, 16'h0, 1'b1},
    '{8'ha9, 8'h00, 16'h202, 16'h1, 16'h1004, 16'h2000, 16'h202, 16'h0, 1'b0}
  };
  tca_transfer_ctrl uut (.clk, .rst_n, .ce, .hsel, .haddr, .htrans,
    .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp,
    .hrdata, .srcReq, .srcFlagClr, .cpuSrcIrq, .swCpuIrq, .memReq, .memWe,
    .memWord, .memAddr, .memWdata, .memAck, .memRdata, .busy, .stopped);
  tca_mem_model mem (.clk, .memReq, .memWe, .memWord, .memAddr, .memWdata,
    .memAck, .memRdata);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // peripheral flags drop when cleared; counts of pulses and accesses
  always @(posedge clk) begin
    if (|srcFlagClr) srcReq <= srcReq & ~srcFlagClr;
    if (|srcFlagClr) nClr <= nClr + 1;
    if (swCpuIrq) nIrq <= nIrq + 1;
    if (memReq && memAck && nAcc == a0) firstA <= memAddr;
    if (memReq && memAck) nAcc <= nAcc + 1;
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // one ahb-lite single transfer; read data lands in rd
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus
  task put(input logic [23:0] a, input logic [15:0] v);
    mem.m[int'(a[23:1])] = v;
  endtask : put
  function automatic logic [15:0] get(input logic [23:0] a);
    return mem.m[int'(a[23:1])];
  endfunction : get
  // descriptor with source 001000 and the given destination
  task desc(input logic [23:0] a, input tca_row_t x, input logic [23:0] d);
    put(a, {x.ma, 8'h00});
    put(a + 2, 16'h1000);
    put(a + 4, {x.mb, d[23:16]});
    put(a + 6, d[15:0]);
    put(a + 8, x.ca);
    put(a + 10, x.cb);
  endtask : desc
  // wait for one activation to start and finish; bounded
  task run;
    int n;
    n = 0;
    while (busy !== 1'b1 && n < 50) begin
      @(posedge clk);
      n++;
    end
    while (busy !== 1'b0 && n < 3000) begin
      @(posedge clk);
      n++;
    end
    repeat (2) @(posedge clk);
  endtask : run
  task test_done;
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : test_done
  // hang guard, far above the expected run of under a thousand cycles
  initial begin
    #300000;
    num_errors++;
    test_done;
  end
  initial begin
    {rst_n, hsel, hwrite, htrans, haddr, hwdata, srcReq} = '0;
    ce = 1'b1;
    {num_errors, n_tests, nAcc, nClr, nIrq, a0} = '0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    put(24'h000424, 16'h0100);
    put(24'h000406, 16'h0100);
    put(24'h000422, 16'h0200);
    put(24'h00042a, 16'h0300);
    put(24'h001000, 16'h1234);
    put(24'h001002, 16'h5678);
    // descriptor modes through source 2
    foreach (rows[i]) begin
      desc(24'hff0100, rows[i], 24'h002000);
      put(24'h002000, 16'h0000);
      bus(1'b1, OFS_SRCEN, 32'h4);
      srcReq[2] <= 1'b1;
      run;
      chk(get(24'h002000), 16'h1234);
      chk(get(24'hff0102), rows[i].es);
      chk(get(24'hff0106), rows[i].ed);
      chk(get(24'hff0108), rows[i].eca);
      chk(get(24'hff010a), rows[i].ecb);
      bus(1'b0, OFS_SRCEN, 32'h0);
      chk(rd, {29'h0, rows[i].een, 2'h0});
      chk(srcReq[2], !rows[i].een);
      chk(cpuSrcIrq[2], !rows[i].een);
      srcReq <= '0;
      $display("row %0d done", i);
    end
    // software start, select set, then clear
    desc(24'hff0100, rows[2], 24'h002000);
    c0 = nIrq;
    a0 = nAcc;
    bus(1'b1, OFS_SWVEC, 32'h83);
    run;
    chk(firstA, 24'h000406);
    chk(nIrq - c0, 1);
    bus(1'b0, OFS_SWVEC, 32'h0);
    chk(rd, 32'h83);
    desc(24'hff0100, rows[0], 24'h002000);
    c0 = nIrq;
    bus(1'b1, OFS_SWVEC, 32'h83);
    run;
    bus(1'b0, OFS_SWVEC, 32'h0);
    chk(rd, 32'h03);
    chk(nIrq - c0, 0);
    $display("software done");
    // chain of two contiguous descriptors, one flag clear
    r = rows[0];
    r.mb = 8'h80;
    desc(24'hff0100, r, 24'h002000);
    desc(24'hff010c, rows[0], 24'h002100);
    put(24'h002100, 16'h0000);
    bus(1'b1, OFS_SRCEN, 32'h4);
    c0 = nClr;
    srcReq[2] <= 1'b1;
    run;
    chk(get(24'h002100), 16'h1234);
    chk(nClr - c0, 1);
    srcReq <= '0;
    $display("chain done");
    // two sources together: lower index first
    desc(24'hff0200, rows[1], 24'h002000);
    desc(24'hff0300, rows[1], 24'h002000);
    bus(1'b1, OFS_SRCEN, 32'h22);
    a0 = nAcc;
    srcReq <= 8'h22;
    run;
    run;
    chk(firstA, 24'h000422);
    bus(1'b0, OFS_SRCEN, 32'h0);
    chk(rd, 32'h0);
    srcReq <= '0;
    $display("priority done");
    // stop bit refused while busy, honoured when idle
    desc(24'hff0100, rows[0], 24'h002000);
    bus(1'b1, OFS_SRCEN, 32'h4);
    srcReq[2] <= 1'b1;
    bus(1'b1, OFS_MSTOP, 32'h7fff);
    run;
    bus(1'b0, OFS_MSTOP, 32'h0);
    chk(rd, 32'h3fff);
    desc(24'hff0100, rows[0], 24'h002000);
    bus(1'b1, OFS_MSTOP, 32'h7fff);
    bus(1'b0, OFS_MSTOP, 32'h0);
    chk(rd, 32'h7fff);
    chk(stopped, 1);
    // clock enable low: a bus write is lost, the stop bit stays
    ce <= 1'b0;
    bus(1'b1, OFS_MSTOP, 32'h3fff);
    ce <= 1'b1;
    bus(1'b0, OFS_MSTOP, 32'h0);
    chk(rd, 32'h7fff);
    // enable zero write refused until enable was read as one
    bus(1'b1, OFS_SWVEC, 32'h83);
    bus(1'b1, OFS_SWVEC, 32'h03);
    bus(1'b0, OFS_SWVEC, 32'h0);
    chk(rd, 32'h83);
    bus(1'b1, OFS_SWVEC, 32'h03);
    bus(1'b0, OFS_SWVEC, 32'h0);
    chk(rd, 32'h03);
    srcReq[2] <= 1'b1;
    repeat (20) @(posedge clk);
    chk(busy, 0);
    bus(1'b1, OFS_MSTOP, 32'h3fff);
    run;
    chk(srcReq[2], 0);
    $display("stop done");
    // second reset restores the registers
    bus(1'b1, OFS_MSTOP, 32'h1234);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    bus(1'b0, OFS_MSTOP, 32'h0);
    chk(rd, 32'h3fff);
    bus(1'b0, OFS_SRCEN, 32'h0);
    chk(rd, 32'h0);
    bus(1'b0, 8'h10, 32'h0);
    chk(rd, 32'h0);
    $display("reset done");
    test_done;
  end
endmodule : tb_top
bind tca_transfer_ctrl tca_transfer_ctrl_props props_i (.clk, .rst_n, .hresp,
  .busy, .stopped, .srcReq, .srcFlagClr, .cpuSrcIrq, .swCpuIrq, .memReq,
  .memWe, .memWord, .memAddr, .memAck);
